// ---- include/csc_pkg.sv ----
// ============================================================================
// Shared constants and carriers for the card socket register bank.
// ============================================================================
package csc_pkg;

    // ========================================================================
    // Register map.
    // ========================================================================
    localparam int unsigned ADDR_W = 26;            // Host address width.
    localparam int unsigned DATA_W = 32;            // Register data width.
    localparam int unsigned CARD_DATA_W = 16;       // Card data bus width.
    localparam int unsigned SOCKETS = 2;            // Socket 0 and socket 1.

    localparam logic [25:0] OFS_CONTROL = 26'h0001800;  // Control register.
    localparam logic [25:0] OFS_SLEEP   = 26'h0001804;  // Sleep-state register.
    localparam logic [25:0] OFS_STATUS  = 26'h0001808;  // Status register, read only.

    // ========================================================================
    // Field positions and reset values.
    // ========================================================================
    localparam int unsigned CTL_W       = 8;        // Control register width.
    localparam int unsigned SLP_W       = 2;        // Sleep-state register width.
    localparam int unsigned STS_W       = 14;       // Status register width.
    localparam int unsigned CTL_RESET   = 0;        // Bits 1:0, socket reset.
    localparam int unsigned CTL_FLOAT_N = 2;        // Bits 3:2, float, active low.
    localparam int unsigned CTL_WAIT_EN = 4;        // Bits 5:4, wait enable.
    localparam int unsigned CTL_VSEL    = 6;        // Bits 7:6, card voltage select.
    localparam int unsigned STS_READY   = 0;        // Bits 1:0, ready/irq.
    localparam int unsigned STS_CDVALID = 2;        // Bits 3:2, card detect valid.
    localparam int unsigned STS_VSENSE  = 4;        // Bits 7:4, two per socket.
    localparam int unsigned STS_WP      = 8;        // Bits 9:8, write protect.
    localparam int unsigned STS_BVD     = 10;       // Bits 13:10, two per socket.
    localparam logic [7:0]  CTL_RST_VAL = 8'h00;    // Control reset value.
    localparam logic [1:0]  SLP_RST_VAL = 2'h0;     // Sleep-state reset value.

    // ========================================================================
    // Carriers.
    // ========================================================================
    // Active-low card strobes, as driven by the host and toward a card.
    typedef struct packed {
        logic oe_n;
        logic we_n;
        logic ior_n;
        logic iow_n;
        logic ce1_n;
        logic ce2_n;
    } csc_strobe_t;

    // Live inputs from one socket.
    typedef struct packed {
        logic       ready_irq;
        logic [1:0] card_detect_n;
        logic [1:0] volt_sense;
        logic       write_protect;
        logic [1:0] battery_detect;
        logic       wait_n;
    } csc_card_in_t;

    // Output values toward one socket.
    typedef struct packed {
        csc_strobe_t      strobe;
        logic             reset;
        logic [25:0]      addr;
        logic [15:0]      data;
    } csc_card_out_t;

    // Output enables toward one socket, high while the pins are driven.
    typedef struct packed {
        logic strobe_oe;
        logic reset_oe;
        logic addr_oe;
        logic data_oe;
    } csc_card_oe_t;

endpackage : csc_pkg

// ---- rtl/csc_socket_pins.sv ----
// ============================================================================
// Output pin driver for one socket: awake, floated and sleep behaviour.
// ============================================================================
module csc_socket_pins #(
    parameter logic SOCK_IDX = 1'b0                  // Socket number.
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    reset_bit,
    input  wire logic                    float_n,
    input  wire logic                    sleep_mode,
    input  wire logic                    sleep_bit,
    input  wire logic                    card_present_n,
    input  wire logic                    select,
    input  wire csc_pkg::csc_strobe_t    host_strobe,
    input  wire logic [25:0]             host_addr,
    input  wire logic [15:0]             host_wdata,
    output csc_pkg::csc_card_out_t       card_out,
    output csc_pkg::csc_card_oe_t        card_oe
);

    // ========================================================================
    // State.
    // ========================================================================
    typedef struct packed {
        csc_pkg::csc_card_out_t out;
        csc_pkg::csc_card_oe_t  oe;
    } csc_pin_state_t;

    csc_pin_state_t s_q;                             // Registered pin state.
    csc_pin_state_t s_d;                             // Next pin state.
    logic           routed;                          // Card present and selected.

    // Strobes reach the card only when it is seated and this socket is chosen.
    assign routed = !card_present_n && (select == SOCK_IDX);

    // Next-state logic; sleep is checked first since it overrides all else.
    always_comb begin
        s_d = s_q;
        if (sleep_mode) begin
            // Sleep bit 0 floats everything, 1 parks at fixed levels. [R11]
            // A floated socket keeps its strobes released even when parked.
            s_d.oe.strobe_oe = sleep_bit && float_n; // [R8] [R12] [R13]
            s_d.oe.reset_oe  = sleep_bit;            // [R12] [R13]
            s_d.oe.addr_oe   = sleep_bit;            // [R12] [R13]
            s_d.oe.data_oe   = sleep_bit;            // [R12] [R13]
            s_d.out.strobe   = '1;                   // [R13]
            s_d.out.reset    = 1'b0;                 // [R13]
            s_d.out.addr     = '0;                   // [R13]
            s_d.out.data     = '0;                   // [R13]
        end else begin
            // A float bit at 0 lets go of the control lines. [R7] [R8]
            s_d.oe.strobe_oe = float_n;              // [R7] [R8]
            s_d.oe.reset_oe  = 1'b1;
            s_d.oe.addr_oe   = 1'b1;
            // Data is only driven during a routed host write.
            s_d.oe.data_oe   = routed && !(host_strobe.we_n && host_strobe.iow_n);
            s_d.out.strobe   = routed ? host_strobe : '1;  // [R8]
            s_d.out.reset    = reset_bit;            // [R6]
            s_d.out.addr     = host_addr;
            s_d.out.data     = host_wdata;
        end
    end

    // Pin state register; reset leaves the socket floated and idle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{out: '{strobe: '1, reset: 1'b0, addr: '0, data: '0},
                     oe:  '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign card_out = s_q.out;
    assign card_oe  = s_q.oe;

endmodule : csc_socket_pins

// ---- rtl/csc_regs.sv ----
// What this block does
// R1 - Status bits 1:0 show socket ready.
// R2 - Status bits 3:2 show card detect validity.
// R3 - Valid reads 0 only if both detects low.
// R4 - Status bits 7:4 show voltage sense pairs.
// R5 - Bits 9:8 write protect, 13:10 battery.
// R6 - Control bits 1:0 assert socket reset.
// R7 - Control bits 3:2 at 0 float lines.
// R8 - Strobes follow host when present, selected.
// R9 - Control bits 5:4 enable socket wait.
// R10 - Software sets bits 7:6 per card voltage.
// R11 - Sleep register bits choose sleep pin behaviour.
// R12 - Sleep bit 0 tristates socket outputs.
// R13 - Sleep bit 1 parks outputs at levels.
// R14 - Registers decode at 1800, 1804, 1808.
// R15 - Unused bits read zero; status writes ignored.
module csc_regs (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // Host register port.
    input  wire logic                      reg_cs,
    input  wire logic                      reg_we,
    input  wire logic [25:0]               reg_addr,
    input  wire logic [31:0]               reg_wdata,
    output logic [31:0]                    reg_rdata,
    output logic                           reg_rvalid,
    // Host card-access side; its inputs all come from outside this clock.
    input  wire csc_pkg::csc_strobe_t      host_strobe,
    input  wire logic [25:0]               host_addr,
    input  wire logic [15:0]               host_wdata,
    input  wire logic                      socket_select,
    input  wire logic                      sleep_mode,
    output logic                           host_wait_n,
    // Socket pins.
    input  wire csc_pkg::csc_card_in_t     card_in [2],
    output csc_pkg::csc_card_out_t         card_out [2],
    output csc_pkg::csc_card_oe_t          card_oe [2],
    output logic [1:0]                     card_voltage_sel
);

    // ========================================================================
    // State.
    // ========================================================================
    // Width of everything that arrives from outside and is synchronised.
    localparam int unsigned EXT_W = 2 * $bits(csc_pkg::csc_card_in_t)
                                  + $bits(csc_pkg::csc_strobe_t) + 26 + 16 + 2;

    typedef struct packed {
        logic [EXT_W-1:0] sync1;                     // First synchroniser stage.
        logic [EXT_W-1:0] sync2;                     // Second synchroniser stage.
        logic [7:0]       control;                   // Socket control register.
        logic [1:0]       sleep_sel;                 // Socket sleep-state register.
        logic [31:0]      rdata;                     // Read answer.
        logic             rvalid;                    // Read answer strobe.
        logic             wait_n;                    // Host wait, active low.
    } csc_regs_state_t;

    csc_regs_state_t       s_q;                      // Registered state.
    csc_regs_state_t       s_d;                      // Next state.
    logic [EXT_W-1:0]      ext_raw;                  // Raw outside levels.
    csc_pkg::csc_card_in_t in_s [2];                 // Synchronised socket inputs.
    csc_pkg::csc_strobe_t  strobe_s;                 // Synchronised host strobes.
    logic [25:0]           addr_s;                   // Synchronised host address.
    logic [15:0]           wdata_s;                  // Synchronised host data.
    logic                  select_s;                 // Synchronised socket select.
    logic                  sleep_s;                  // Synchronised sleep request.
    logic [13:0]           status;                   // Live status word.
    logic [1:0]            card_valid;               // Card detect valid per socket.

    // ========================================================================
    // Input synchronisation.
    // ========================================================================
    // Every pin input goes through two flops. Multi-bit address and data are
    // not coherent across the crossing; the host must hold them steady around
    // a strobe, which is the normal card-cycle discipline anyway.
    assign ext_raw = {card_in[1], card_in[0], host_strobe, host_addr, host_wdata,
                      socket_select, sleep_mode};

    // Only the second stage is unpacked and read by logic.
    assign {in_s[1], in_s[0], strobe_s, addr_s, wdata_s, select_s, sleep_s} = s_q.sync2;

    // ========================================================================
    // Status word.
    // ========================================================================
    // Card detect valid is low only when both detect inputs are low. [R3]
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            card_valid[i] = |in_s[i].card_detect_n;  // [R3]
        end
    end

    // Assemble the live status word; nothing here is stored by software.
    always_comb begin
        status = '0;
        status[csc_pkg::STS_READY]       = in_s[0].ready_irq;       // [R1]
        status[csc_pkg::STS_READY+1]     = in_s[1].ready_irq;       // [R1]
        status[csc_pkg::STS_CDVALID]     = card_valid[0];           // [R2]
        status[csc_pkg::STS_CDVALID+1]   = card_valid[1];           // [R2]
        status[csc_pkg::STS_VSENSE+:2]   = in_s[0].volt_sense;      // [R4]
        status[csc_pkg::STS_VSENSE+2+:2] = in_s[1].volt_sense;      // [R4]
        status[csc_pkg::STS_WP]          = in_s[0].write_protect;   // [R5]
        status[csc_pkg::STS_WP+1]        = in_s[1].write_protect;   // [R5]
        status[csc_pkg::STS_BVD+:2]      = in_s[0].battery_detect;  // [R5]
        status[csc_pkg::STS_BVD+2+:2]    = in_s[1].battery_detect;  // [R5]
    end

    // ========================================================================
    // Register access and wait generation.
    // ========================================================================
    // One process computes every next value of the block's state.
    always_comb begin
        s_d        = s_q;
        s_d.sync1  = ext_raw;
        s_d.sync2  = s_q.sync1;
        s_d.rvalid = 1'b0;

        // Register writes; the status location and unmapped offsets are
        // silently dropped so a stray write cannot disturb a socket.
        if (reg_cs && reg_we) begin
            case (reg_addr)
                csc_pkg::OFS_CONTROL: begin
                    s_d.control = reg_wdata[7:0];                   // [R14]
                end
                csc_pkg::OFS_SLEEP: begin
                    s_d.sleep_sel = reg_wdata[1:0];                 // [R14] [R11]
                end
                default: begin
                    s_d.control = s_q.control;                      // [R15]
                end
            endcase
        end

        // Register reads answer one cycle later; upper bits read zero.
        if (reg_cs && !reg_we) begin
            s_d.rvalid = 1'b1;
            case (reg_addr)
                csc_pkg::OFS_CONTROL: begin
                    s_d.rdata = {24'h000000, s_q.control};          // [R14] [R15]
                end
                csc_pkg::OFS_SLEEP: begin
                    s_d.rdata = {30'h00000000, s_q.sleep_sel};      // [R14] [R15]
                end
                csc_pkg::OFS_STATUS: begin
                    s_d.rdata = {18'h00000, status};                // [R14] [R1]
                end
                default: begin
                    s_d.rdata = 32'h00000000;                       // [R15]
                end
            endcase
        end

        // A socket may stall the host only when its wait enable is set. [R9]
        s_d.wait_n = !((s_q.control[csc_pkg::CTL_WAIT_EN]   && !in_s[0].wait_n) ||
                       (s_q.control[csc_pkg::CTL_WAIT_EN+1] && !in_s[1].wait_n));
    end

    // State register; control starts at zero, which floats the strobes of both sockets.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{sync1: '0, sync2: '0, control: csc_pkg::CTL_RST_VAL,
                     sleep_sel: csc_pkg::SLP_RST_VAL, rdata: 32'h00000000,
                     rvalid: 1'b0, wait_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata   = s_q.rdata;
    assign reg_rvalid  = s_q.rvalid;
    assign host_wait_n = s_q.wait_n;
    // The voltage select bits only go out to the supply switch; software
    // owns their meaning.
    assign card_voltage_sel = s_q.control[csc_pkg::CTL_VSEL+:2];

    // ========================================================================
    // Socket pin drivers.
    // ========================================================================
    // Both sockets share one driver design, differing only in their index.
    for (genvar g = 0; g < 2; g++) begin : g_sock
        csc_socket_pins #(
            .SOCK_IDX       (1'(g))
        ) u_pins (
            .clk            (clk),
            .rstn           (rstn),
            .reset_bit      (s_q.control[csc_pkg::CTL_RESET+g]),    // [R6]
            .float_n        (s_q.control[csc_pkg::CTL_FLOAT_N+g]),  // [R7]
            .sleep_mode     (sleep_s),
            .sleep_bit      (s_q.sleep_sel[g]),                     // [R11]
            .card_present_n (card_valid[g]),                        // [R8]
            .select         (select_s),
            .host_strobe    (strobe_s),
            .host_addr      (addr_s),
            .host_wdata     (wdata_s),
            .card_out       (card_out[g]),
            .card_oe        (card_oe[g])
        );
    end

endmodule : csc_regs

// ---- testbench/csc_properties.sv ----
// ============================================================================
// Port-level checker for the card socket register bank.
// ============================================================================
module csc_properties (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  reg_cs,
    input wire logic                  reg_we,
    input wire logic [25:0]           reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic [31:0]           reg_rdata,
    input wire logic                  reg_rvalid,
    input wire csc_pkg::csc_strobe_t  host_strobe,
    input wire logic [25:0]           host_addr,
    input wire logic [15:0]           host_wdata,
    input wire logic                  socket_select,
    input wire logic                  sleep_mode,
    input wire logic                  host_wait_n,
    input wire csc_pkg::csc_card_in_t card_in [2],
    input wire csc_pkg::csc_card_out_t card_out [2],
    input wire csc_pkg::csc_card_oe_t card_oe [2],
    input wire logic [1:0]            card_voltage_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // A read request taken at one edge.
    sequence s_read(logic [25:0] a);
        reg_cs && !reg_we && reg_addr == a;
    endsequence
    // Sleep held long enough for the pin pipeline to settle.
    sequence s_asleep;
        sleep_mode [*4];
    endsequence

    a_read_answer: assert property (reg_cs && !reg_we |=> reg_rvalid)
        else $error("read got no answer");
    a_write_quiet: assert property (reg_cs && reg_we |=> !reg_rvalid)
        else $error("write produced a read answer");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_cs && !reg_we))
        else $error("answer without a read");
    a_status_upper: assert property (s_read(csc_pkg::OFS_STATUS) |=>
        reg_rdata[31:14] == 18'h0) else $error("status upper bits not zero");
    a_ctl_upper: assert property (s_read(csc_pkg::OFS_CONTROL) |=>
        reg_rdata[31:8] == 24'h0) else $error("control upper bits not zero");
    a_sleep_upper: assert property (s_read(csc_pkg::OFS_SLEEP) |=>
        reg_rdata[31:2] == 30'h0) else $error("sleep upper bits not zero");
    a_unmapped_zero: assert property (reg_cs && !reg_we
        && reg_addr != csc_pkg::OFS_CONTROL && reg_addr != csc_pkg::OFS_SLEEP
        && reg_addr != csc_pkg::OFS_STATUS |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_card_absent: assert property ((card_in[0].card_detect_n == 2'h3) [*3]
        ##0 s_read(csc_pkg::OFS_STATUS) |=> reg_rdata[2])
        else $error("absent card reads valid");
    a_sleep_park: assert property (s_asleep |-> card_out[0].strobe == 6'h3f
        && card_out[0].addr == 26'h0 && card_out[0].data == 16'h0 && !card_out[0].reset
        && card_oe[0].data_oe == card_oe[0].addr_oe)
        else $error("sleep levels wrong");
    a_wait_idle: assert property ((card_in[0].wait_n && card_in[1].wait_n) [*4]
        |-> host_wait_n) else $error("host wait without a card wait");
    a_strobe_idle: assert property ((!sleep_mode && host_strobe == 6'h3f) [*4]
        |-> !card_oe[1].strobe_oe || card_out[1].strobe == 6'h3f)
        else $error("card strobe low while host idle");
endmodule : csc_properties

bind csc_regs csc_properties u_props (.clk(clk), .rstn(rstn), .reg_cs(reg_cs),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .host_strobe(host_strobe), .host_addr(host_addr),
    .host_wdata(host_wdata), .socket_select(socket_select), .sleep_mode(sleep_mode),
    .host_wait_n(host_wait_n), .card_in(card_in), .card_out(card_out),
    .card_oe(card_oe), .card_voltage_sel(card_voltage_sel));

// ---- testbench/csc_sockets.sv ----
// ============================================================================
// Behavioural model of the two card sockets.
// ============================================================================
module csc_sockets (
    input  wire csc_pkg::csc_card_in_t  cfg [2],      // Static card levels.
    input  wire logic [1:0]             slow,         // Card stretches reads.
    input  wire csc_pkg::csc_card_out_t card_out [2],
    input  wire csc_pkg::csc_card_oe_t  card_oe [2],
    output csc_pkg::csc_card_in_t       card_in [2]
);
    timeunit 1ns;
    timeprecision 1ps;
    // A card held in reset is busy, and a slow card waits while its
    // output-enable strobe is driven low.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            card_in[i] = cfg[i];
            card_in[i].ready_irq = cfg[i].ready_irq
                & !(card_oe[i].reset_oe & card_out[i].reset);
            card_in[i].wait_n = !(slow[i] & card_oe[i].strobe_oe
                & !card_out[i].strobe.oe_n);
        end
    end
endmodule : csc_sockets

// ---- testbench/testbench.sv ----
// ============================================================================
// Self-checking bench for the card socket register bank.
// ============================================================================
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, reg_cs = 1'b0, reg_we = 1'b0, sleep_mode = 1'b0;
    logic socket_select = 1'b0, host_wait_n, reg_rvalid;
    logic [25:0] reg_addr = 26'h0, host_addr = 26'h155;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
    logic [15:0] host_wdata = 16'h0;
    logic [1:0] slow = 2'h0, card_voltage_sel;
    csc_pkg::csc_strobe_t host_strobe = 6'h3f;
    csc_pkg::csc_card_in_t cfg [2] = '{9'h001, 9'h001}, card_in [2];
    csc_pkg::csc_card_out_t card_out [2];
    csc_pkg::csc_card_oe_t card_oe [2];
    int num_errors = 0, comparisons = 0, cycles = 0;
    localparam logic [8:0] PAT [4] = '{9'h1ab, 9'h055, 9'h001, 9'h1ff};

    always #12.5 clk = !clk;
    csc_regs dut (.clk(clk), .rstn(rstn), .reg_cs(reg_cs), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .host_strobe(host_strobe), .host_addr(host_addr),
        .host_wdata(host_wdata), .socket_select(socket_select), .sleep_mode(sleep_mode),
        .host_wait_n(host_wait_n), .card_in(card_in), .card_out(card_out),
        .card_oe(card_oe), .card_voltage_sel(card_voltage_sel));
    csc_sockets sockets (.cfg(cfg), .slow(slow), .card_out(card_out), .card_oe(card_oe),
        .card_in(card_in));

    // Compare one value and count it.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [25:0] a, input logic [31:0] d);
        @(negedge clk) {reg_cs, reg_we, reg_addr, reg_wdata} = {2'h3, a, d};
        @(negedge clk) {reg_cs, reg_we} = 2'h0;
    endtask : wr
    // The answer is awaited under a bound; a lost answer leaves x in rd.
    task automatic rdr(input logic [25:0] a);
        @(negedge clk) {reg_cs, reg_we, reg_addr} = {2'h2, a};
        @(negedge clk) reg_cs = 1'b0;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk);
        rd = (reg_rvalid === 1'b1) ? reg_rdata : 32'hx;
    endtask : rdr
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask : settle
    // Status image built from the card levels alone.
    function automatic logic [31:0] exp_st(input csc_pkg::csc_card_in_t a, b);
        return {18'h0, b.battery_detect, a.battery_detect, b.write_protect, a.write_protect,
            b.volt_sense, a.volt_sense, |b.card_detect_n, |a.card_detect_n,
            b.ready_irq, a.ready_irq};
    endfunction : exp_st

    task automatic t_regs();
        rdr(csc_pkg::OFS_CONTROL); check(rd, 32'h0);
        rdr(csc_pkg::OFS_SLEEP); check(rd, 32'h0);
        check(card_oe[0].strobe_oe, 1'b0);
        wr(csc_pkg::OFS_CONTROL, 32'hffff_ffcc); rdr(csc_pkg::OFS_CONTROL);
        check(rd, 32'hcc);
        check(card_voltage_sel, 2'h3);
        wr(csc_pkg::OFS_SLEEP, 32'hffff_ffff); rdr(csc_pkg::OFS_SLEEP); check(rd, 32'h3);
        wr(csc_pkg::OFS_STATUS, 32'h0); wr(26'h0001810, 32'h0);
        rdr(csc_pkg::OFS_CONTROL); check(rd, 32'hcc);
        rdr(26'h000180c); check(rd, 32'h0);
        $display("test registers done");
    endtask : t_regs
    task automatic t_status();
        for (int t = 0; t < 4; t++) begin
            @(negedge clk) begin cfg[0] = PAT[t]; cfg[1] = PAT[3 - t]; end
            settle(); rdr(csc_pkg::OFS_STATUS);
            check(rd, exp_st(PAT[t], PAT[3 - t]));
        end
        @(negedge clk) cfg = '{9'h101, 9'h101};
        $display("test status done");
    endtask : t_status
    task automatic t_reset_bits();
        wr(csc_pkg::OFS_CONTROL, 32'h01); settle();
        check({card_out[1].reset, card_out[0].reset}, 2'h1);
        rdr(csc_pkg::OFS_STATUS); check(rd[1:0], 2'h2);
        wr(csc_pkg::OFS_CONTROL, 32'h02); settle();
        check({card_out[1].reset, card_out[0].reset}, 2'h2);
        $display("test socket reset done");
    endtask : t_reset_bits
    task automatic t_strobes();
        wr(csc_pkg::OFS_CONTROL, 32'h1c);
        @(negedge clk) begin host_strobe.oe_n = 1'b0; slow = 2'h1; end
        settle();
        check({card_oe[0].strobe_oe, card_out[0].strobe.oe_n}, 2'h2);
        check(card_out[1].strobe.oe_n, 1'b1);
        // The card's wait returns through the synchroniser and wait flops, so it lags the strobe.
        settle(); check(host_wait_n, 1'b0);
        wr(csc_pkg::OFS_CONTROL, 32'h0c); settle(); check(host_wait_n, 1'b1);
        @(negedge clk) socket_select = 1'b1;
        settle(); check({card_out[1].strobe.oe_n, card_out[0].strobe.oe_n}, 2'h1);
        @(negedge clk) socket_select = 1'b0;
        @(negedge clk) cfg[0].card_detect_n = 2'h2;
        settle(); check(card_out[0].strobe.oe_n, 1'b1);
        wr(csc_pkg::OFS_CONTROL, 32'h00); settle(); check(card_oe[0].strobe_oe, 1'b0);
        @(negedge clk) host_strobe = 6'h3f;
        $display("test strobes done");
    endtask : t_strobes
    task automatic t_sleep();
        wr(csc_pkg::OFS_SLEEP, 32'h1); wr(csc_pkg::OFS_CONTROL, 32'h0c);
        @(negedge clk) sleep_mode = 1'b1;
        settle();
        check(card_oe[0], 4'hf);
        check({card_out[0].strobe, card_out[0].reset, card_out[0].addr}, 33'h1f8000000);
        check(card_out[0].data, 16'h0);
        check(card_oe[1], 4'h0);
        // A floated socket keeps its strobes released even while parked.
        wr(csc_pkg::OFS_CONTROL, 32'h00); settle(); check(card_oe[0], 4'h7);
        @(negedge clk) sleep_mode = 1'b0;
        $display("test sleep done");
    endtask : t_sleep

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // Cuts a hang short; the whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_regs(); t_status(); t_reset_bits(); t_strobes(); t_sleep();
        conclude();
    end
endmodule : testbench
